/* design/hmsq_map.svh */
// homing sequencer constants: mode codes, step indices, direction and speed levels, sensor bits
// assumes inclusion by the package, the core and the bench
`ifndef HMSQ_MAP_SVH
`define HMSQ_MAP_SVH

`define HM_MODE_W   5
`define HM_MODE_12  5'h0C
`define HM_MODE_13  5'h0D
`define HM_MODE_14  5'h0E
`define HM_MODE_15  5'h0F
`define HM_MODE_16  5'h10
`define HM_MODE_17  5'h11
`define HM_MODE_18  5'h12
`define HM_MODE_19  5'h13

`define HM_STEP_W   3
`define HM_STEP0    3'h0
`define HM_STEP1    3'h1
`define HM_STEP2    3'h2
`define HM_STEP3    3'h3
`define HM_STEP4    3'h4

`define HM_FWD      1'b1
`define HM_REV      1'b0
`define HM_HI       1'b1
`define HM_LO       1'b0

// sensor bit positions in the synchroniser vector
`define HM_B_HOME   0
`define HM_B_FLIM   1
`define HM_B_RLIM   2
`define HM_B_INDEX  3
`define HM_NSENS    4

`endif

/* design/hmsq_pkg.sv */
// homing sequencer types: states, step events, step endings, step record
// assumes hmsq_map.svh is on the include path
`include "hmsq_map.svh"

package hmsq_pkg;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_MOVE  = 7'h02,
        ST_HALT  = 7'h04,
        ST_SEEK  = 7'h08,
        ST_FINP  = 7'h10,
        ST_FINI  = 7'h20,
        ST_FAULT = 7'h40
    } hmsq_state_e;

    typedef enum logic [2:0] {
        EV_HS_ON, EV_HS_OFF, EV_RL_ON, EV_RL_OFF, EV_FL_ON, EV_FL_OFF
    } hmsq_ev_e;

    // what a step does once its event arrives
    typedef enum logic [1:0] {
        END_STOP, END_RUN, END_IDX, END_HOME
    } hmsq_end_e;

    typedef struct packed {
        logic                   fwd;
        logic                   hi;
        hmsq_ev_e               ev;
        hmsq_end_e              fin;
        logic [`HM_STEP_W-1:0]  nxt;
    } hmsq_step_s;

endpackage : hmsq_pkg

/* design/hmsq_core.sv */
// homing sequencer for modes 12 to 14 and 17 to 19 of a servo axis; 15 and 16 are rejected
// assumes: sensor pins asynchronous, start/mode/position/stopped on clk_i

`include "hmsq_map.svh"

module hmsq_core #(
    parameter int POS_W = 32
) (
    input  wire logic                   clk_i,
    input  wire logic                   reset_i,
    input  wire logic                   start_i,
    input  wire logic [`HM_MODE_W-1:0]  mode_i,
    input  wire logic                   home_switch_i,
    input  wire logic                   forward_limit_i,
    input  wire logic                   reverse_limit_i,
    input  wire logic                   index_pulse_i,
    input  wire logic [POS_W-1:0]       position_i,
    input  wire logic                   stopped_i,
    input  wire logic                   alarm_clr_i,
    output logic                        run_o,
    output logic                        dir_fwd_o,
    output logic                        speed_hi_o,
    output logic                        busy_o,
    output logic                        done_o,
    output logic                        alarm_o,
    output logic                        reject_o,
    output logic [POS_W-1:0]            home_pos_o
);
    import hmsq_pkg::*;

    if (POS_W < 2) begin : g_chk
        $error("hmsq_core: POS_W must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////////
    // step table

    function automatic hmsq_step_s mk(input logic f, input logic h,
            input hmsq_ev_e e, input hmsq_end_e n,
            input logic [`HM_STEP_W-1:0] x);
        hmsq_step_s r;
        r.fwd = f;
        r.hi  = h;
        r.ev  = e;
        r.fin = n;
        r.nxt = x;
        return r;
    endfunction : mk

    function automatic hmsq_step_s step_of(
            input logic [`HM_MODE_W-1:0] m,
            input logic [`HM_STEP_W-1:0] s);
        hmsq_step_s r;
        r = mk(`HM_REV, `HM_LO, EV_HS_ON, END_STOP, `HM_STEP0);
        case (m)
            `HM_MODE_12: begin
                case (s)
                    `HM_STEP0: r = mk(`HM_REV, `HM_HI, EV_HS_ON,
                                      END_STOP, `HM_STEP1);
                    `HM_STEP1: r = mk(`HM_FWD, `HM_LO, EV_HS_OFF,
                                      END_STOP, `HM_STEP2);
                    `HM_STEP2: r = mk(`HM_REV, `HM_LO, EV_HS_ON,
                                      END_IDX, `HM_STEP2);
                    `HM_STEP3: r = mk(`HM_FWD, `HM_HI, EV_HS_ON,
                                      END_RUN, `HM_STEP4);
                    default:   r = mk(`HM_FWD, `HM_LO, EV_HS_OFF,
                                      END_STOP, `HM_STEP2);
                endcase
            end
            `HM_MODE_13: begin
                case (s)
                    `HM_STEP0: r = mk(`HM_REV, `HM_HI, EV_HS_ON,
                                      END_RUN, `HM_STEP1);
                    `HM_STEP1: r = mk(`HM_REV, `HM_LO, EV_HS_OFF,
                                      END_STOP, `HM_STEP2);
                    `HM_STEP2: r = mk(`HM_FWD, `HM_LO, EV_HS_ON,
                                      END_IDX, `HM_STEP2);
                    `HM_STEP3: r = mk(`HM_FWD, `HM_HI, EV_HS_ON,
                                      END_STOP, `HM_STEP4);
                    default:   r = mk(`HM_REV, `HM_LO, EV_HS_OFF,
                                      END_STOP, `HM_STEP2);
                endcase
            end
            `HM_MODE_14: begin
                case (s)
                    `HM_STEP0: r = mk(`HM_REV, `HM_HI, EV_HS_ON,
                                      END_RUN, `HM_STEP1);
                    `HM_STEP1: r = mk(`HM_REV, `HM_LO, EV_HS_OFF,
                                      END_STOP, `HM_STEP2);
                    // narrow zone: may overshoot, next step waits for off
                    `HM_STEP2: r = mk(`HM_FWD, `HM_LO, EV_HS_ON,
                                      END_STOP, `HM_STEP3);
                    `HM_STEP3: r = mk(`HM_REV, `HM_LO, EV_HS_OFF,
                                      END_IDX, `HM_STEP3);
                    default:   r = mk(`HM_FWD, `HM_HI, EV_HS_ON,
                                      END_STOP, `HM_STEP3);
                endcase
            end
            `HM_MODE_17: begin
                if (s == `HM_STEP0) begin
                    r = mk(`HM_REV, `HM_HI, EV_RL_ON, END_STOP, `HM_STEP1);
                end else begin
                    r = mk(`HM_FWD, `HM_LO, EV_RL_OFF, END_HOME, `HM_STEP1);
                end
            end
            `HM_MODE_18: begin
                if (s == `HM_STEP0) begin
                    r = mk(`HM_FWD, `HM_HI, EV_FL_ON, END_STOP, `HM_STEP1);
                end else begin
                    r = mk(`HM_REV, `HM_LO, EV_FL_OFF, END_HOME, `HM_STEP1);
                end
            end
            default: begin
                if (s == `HM_STEP0) begin
                    r = mk(`HM_FWD, `HM_HI, EV_HS_ON, END_STOP, `HM_STEP1);
                end else begin
                    r = mk(`HM_REV, `HM_LO, EV_HS_OFF, END_HOME, `HM_STEP1);
                end
            end
        endcase
        return r;
    endfunction : step_of

    ////////////////////////////////////////////////////////////////////////
    // sensor synchronisers: a level counts once stages two and three agree

    logic [`HM_NSENS-1:0] s1_q;
    logic [`HM_NSENS-1:0] s2_q;
    logic [`HM_NSENS-1:0] s3_q;
    logic [`HM_NSENS-1:0] lvl_q;
    logic [`HM_NSENS-1:0] pins_w;
    logic [`HM_NSENS-1:0] lvl_d;
    logic [`HM_NSENS-1:0] rise_w;
    logic [`HM_NSENS-1:0] fall_w;

    assign pins_w = {index_pulse_i, reverse_limit_i, forward_limit_i,
                     home_switch_i};
    assign lvl_d  = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    assign rise_w = lvl_d & ~lvl_q;
    assign fall_w = ~lvl_d & lvl_q;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            lvl_q <= '0;
        end else begin
            s1_q  <= pins_w;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode

    hmsq_state_e              st_q;
    hmsq_state_e              st_d;
    logic [`HM_MODE_W-1:0]    mode_q;
    logic [`HM_MODE_W-1:0]    mode_d;
    logic [`HM_STEP_W-1:0]    step_q;
    logic [`HM_STEP_W-1:0]    step_d;
    logic [`HM_STEP_W-1:0]    start_step_w;
    logic [`HM_STEP_W-1:0]    turn_step_w;
    logic                     rl_seen_q;
    logic                     rl_seen_d;
    logic                     moving_w;
    logic                     active_w;
    logic                     nearz_w;
    logic                     m12_14_w;
    logic                     m19_w;
    logic                     mode_ok_w;
    logic                     go_w;
    logic                     turn_w;
    logic                     abort_w;
    logic                     hit_w;
    logic                     latch_w;
    hmsq_step_s               cur_w;
    hmsq_step_s               nx_w;

    assign m12_14_w  = (mode_q == `HM_MODE_12) | (mode_q == `HM_MODE_13)
                     | (mode_q == `HM_MODE_14);
    assign m19_w     = (mode_q == `HM_MODE_19);
    // reserved 15/16 and everything outside 12..19 fall through here
    assign mode_ok_w = (mode_i >= `HM_MODE_12) & (mode_i <= `HM_MODE_19)
                     & (mode_i != `HM_MODE_15)
                     & (mode_i != `HM_MODE_16);
    assign go_w      = start_i & (st_q == ST_IDLE) & ~alarm_o & mode_ok_w;
    assign active_w  = (mode_i == `HM_MODE_17) ? lvl_q[`HM_B_RLIM]
                     : (mode_i == `HM_MODE_18) ? lvl_q[`HM_B_FLIM]
                     : lvl_q[`HM_B_HOME];
    assign nearz_w   = (mode_i == `HM_MODE_12);
    // active start enters the sequence part way through
    assign start_step_w = ~active_w ? `HM_STEP0
                        : nearz_w ? `HM_STEP4
                        : (mode_i == `HM_MODE_14) ? `HM_STEP3
                        : `HM_STEP1;
    assign turn_step_w = (mode_q == `HM_MODE_14) ? `HM_STEP4
                                                 : `HM_STEP3;
    assign moving_w = (st_q == ST_MOVE) | (st_q == ST_SEEK);
    assign cur_w    = step_of(mode_q, step_q);

    assign turn_w  = m12_14_w & moving_w & ~dir_fwd_o & ~rl_seen_q
                   & rise_w[`HM_B_RLIM] & ~rise_w[`HM_B_FLIM];
    assign abort_w = busy_o & (
          (m12_14_w & (rise_w[`HM_B_FLIM]
                       | (rise_w[`HM_B_RLIM] & ~turn_w)))
        | (m19_w & (rise_w[`HM_B_FLIM] | rise_w[`HM_B_RLIM]))
        );

    always_comb begin
        case (cur_w.ev)
            EV_HS_ON:  hit_w = rise_w[`HM_B_HOME];
            EV_HS_OFF: hit_w = fall_w[`HM_B_HOME];
            EV_RL_ON:  hit_w = rise_w[`HM_B_RLIM];
            EV_RL_OFF: hit_w = fall_w[`HM_B_RLIM];
            EV_FL_ON:  hit_w = rise_w[`HM_B_FLIM];
            default:   hit_w = fall_w[`HM_B_FLIM];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb begin
        st_d      = st_q;
        step_d    = step_q;
        rl_seen_d = rl_seen_q;
        latch_w   = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (go_w) begin
                    st_d      = ST_MOVE;
                    step_d    = start_step_w;
                    rl_seen_d = 1'b0;
                end
            end
            ST_MOVE: begin
                if (abort_w) begin
                    st_d = ST_FAULT;
                end else if (turn_w) begin
                    st_d      = ST_HALT;
                    step_d    = turn_step_w;
                    rl_seen_d = 1'b1;
                end else if (hit_w) begin
                    case (cur_w.fin)
                        END_STOP: begin
                            st_d   = ST_HALT;
                            step_d = cur_w.nxt;
                        end
                        END_RUN:  step_d = cur_w.nxt;
                        END_IDX:  st_d = ST_SEEK;
                        default:  st_d = ST_FINP;
                    endcase
                end
            end
            ST_HALT: begin
                if (abort_w) begin
                    st_d = ST_FAULT;
                end else if (stopped_i) begin
                    st_d = ST_MOVE;
                end
            end
            ST_SEEK: begin
                if (abort_w) begin
                    st_d = ST_FAULT;
                end else if (turn_w) begin
                    st_d      = ST_HALT;
                    step_d    = turn_step_w;
                    rl_seen_d = 1'b1;
                end else if (rise_w[`HM_B_INDEX]) begin
                    st_d    = ST_FINI;
                    latch_w = 1'b1;
                end
            end
            ST_FINP: begin
                if (abort_w) begin
                    st_d = ST_FAULT;
                end else if (stopped_i) begin
                    st_d    = ST_IDLE;
                    latch_w = 1'b1;
                end
            end
            ST_FINI: begin
                if (abort_w) begin
                    st_d = ST_FAULT;
                end else if (stopped_i) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                if (~alarm_o) begin
                    st_d = ST_IDLE;
                end
            end
        endcase
    end

    assign mode_d = go_w ? mode_i : mode_q;
    assign nx_w   = step_of(mode_d, step_d);

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_q      <= ST_IDLE;
            mode_q    <= `HM_MODE_12;
            step_q    <= `HM_STEP0;
            rl_seen_q <= 1'b0;
        end else begin
            st_q      <= st_d;
            mode_q    <= mode_d;
            step_q    <= step_d;
            rl_seen_q <= rl_seen_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; index search keeps the direction and speed it had

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            run_o      <= 1'b0;
            dir_fwd_o  <= `HM_REV;
            speed_hi_o <= `HM_LO;
            busy_o     <= 1'b0;
        end else begin
            run_o  <= (st_d == ST_MOVE) | (st_d == ST_SEEK);
            busy_o <= (st_d != ST_IDLE) & (st_d != ST_FAULT);
            if (st_d == ST_MOVE) begin
                dir_fwd_o  <= nx_w.fwd;
                speed_hi_o <= nx_w.hi;
            end
        end
    end

    // alarm set wins over a clear in the same cycle
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            alarm_o    <= 1'b0;
            done_o     <= 1'b0;
            reject_o   <= 1'b0;
            home_pos_o <= '0;
        end else begin
            alarm_o  <= (st_d == ST_FAULT) & (st_q != ST_FAULT)
                      | (alarm_o & ~alarm_clr_i);
            done_o   <= go_w ? 1'b0
                      : (done_o | (((st_q == ST_FINP) | (st_q == ST_FINI))
                                   & (st_d == ST_IDLE)));
            reject_o <= start_i & (st_q == ST_IDLE) & ~mode_ok_w;
            if (latch_w) begin
                home_pos_o <= position_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_m12_act;
        @(posedge clk_i) disable iff (reset_i)
        go_w && mode_i == `HM_MODE_12 && lvl_q[`HM_B_HOME]
            |=> run_o && dir_fwd_o && !speed_hi_o;
    endproperty
    a_m12_act: assert property (p_m12_act)
        else $error("mode 12 active start not forward low");

    property p_hs_inact;
        @(posedge clk_i) disable iff (reset_i)
        go_w && !lvl_q[`HM_B_HOME] && mode_i >= `HM_MODE_12
            && mode_i <= `HM_MODE_14
            |=> run_o && !dir_fwd_o && speed_hi_o;
    endproperty
    a_hs_inact: assert property (p_hs_inact)
        else $error("modes 12-14 inactive start not reverse high");

    property p_turn;
        @(posedge clk_i) disable iff (reset_i)
        turn_w && !rise_w[`HM_B_FLIM]
            |=> st_q == ST_HALT && !run_o && !alarm_o ##1 rl_seen_q;
    endproperty
    a_turn: assert property (p_turn)
        else $error("first reverse limit did not turn the axis");

    property p_abort;
        @(posedge clk_i) disable iff (reset_i)
        busy_o && m12_14_w && rise_w[`HM_B_FLIM]
            |=> alarm_o && !run_o && !busy_o;
    endproperty
    a_abort: assert property (p_abort)
        else $error("forward limit did not abort modes 12-14");

    property p_m13_act;
        @(posedge clk_i) disable iff (reset_i)
        go_w && mode_i == `HM_MODE_13 && lvl_q[`HM_B_HOME]
            |=> run_o && !dir_fwd_o && !speed_hi_o && step_q == `HM_STEP1;
    endproperty
    a_m13_act: assert property (p_m13_act)
        else $error("mode 13 active start not reverse low");

    property p_m14_act;
        @(posedge clk_i) disable iff (reset_i)
        go_w && mode_i == `HM_MODE_14 && lvl_q[`HM_B_HOME]
            |=> run_o && !dir_fwd_o && !speed_hi_o && step_q == `HM_STEP3;
    endproperty
    a_m14_act: assert property (p_m14_act)
        else $error("mode 14 active start not reverse low");

    property p_rsvd;
        @(posedge clk_i) disable iff (reset_i)
        start_i && st_q == ST_IDLE
            && (mode_i == `HM_MODE_15 || mode_i == `HM_MODE_16)
            |=> reject_o && !busy_o && !run_o;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved mode started a sequence");

    property p_m17;
        @(posedge clk_i) disable iff (reset_i)
        go_w && mode_i == `HM_MODE_17 && !lvl_q[`HM_B_RLIM]
            |=> run_o && !dir_fwd_o && speed_hi_o;
    endproperty
    a_m17: assert property (p_m17)
        else $error("mode 17 inactive start not reverse high");

    property p_m17_act;
        @(posedge clk_i) disable iff (reset_i)
        go_w && mode_i == `HM_MODE_17 && lvl_q[`HM_B_RLIM]
            |=> run_o && dir_fwd_o && !speed_hi_o;
    endproperty
    a_m17_act: assert property (p_m17_act)
        else $error("mode 17 active start not forward low");

    property p_m18_act;
        @(posedge clk_i) disable iff (reset_i)
        go_w && mode_i == `HM_MODE_18 && lvl_q[`HM_B_FLIM]
            |=> run_o && !dir_fwd_o && !speed_hi_o;
    endproperty
    a_m18_act: assert property (p_m18_act)
        else $error("mode 18 active start not reverse low");

    property p_m19_act;
        @(posedge clk_i) disable iff (reset_i)
        go_w && mode_i == `HM_MODE_19 && lvl_q[`HM_B_HOME]
            |=> run_o && !dir_fwd_o && !speed_hi_o;
    endproperty
    a_m19_act: assert property (p_m19_act)
        else $error("mode 19 active start not reverse low");

    property p_m19_lim;
        @(posedge clk_i) disable iff (reset_i)
        busy_o && m19_w && (rise_w[`HM_B_FLIM] || rise_w[`HM_B_RLIM])
            |=> alarm_o ##1 alarm_o || $past(alarm_clr_i);
    endproperty
    a_m19_lim: assert property (p_m19_lim)
        else $error("limit in mode 19 did not raise alarm");

    property p_index;
        @(posedge clk_i) disable iff (reset_i)
        st_q == ST_SEEK && !abort_w && !turn_w && rise_w[`HM_B_INDEX]
            |=> home_pos_o == $past(position_i) && !run_o;
    endproperty
    a_index: assert property (p_index)
        else $error("index pulse did not latch home");

    property p_done;
        @(posedge clk_i) disable iff (reset_i)
        $rose(done_o) |-> !run_o && !busy_o && !alarm_o
            && $past(stopped_i);
    endproperty
    a_done: assert property (p_done)
        else $error("done raised while moving");

endmodule : hmsq_core

/* bench/hmsq_axis.sv */
// axis model: position, home switch zone, limits, index marks
// assumes run/dir/speed from the sequencer on the same clock
module hmsq_axis (
    input  wire logic        clk_i,
    input  wire logic        load_i,
    input  wire logic [9:0]  load_pos_i,
    input  wire logic        run_i,
    input  wire logic        dir_fwd_i,
    input  wire logic        speed_hi_i,
    output logic             home_switch_o,
    output logic             forward_limit_o,
    output logic             reverse_limit_o,
    output logic             index_pulse_o,
    output logic             stopped_o,
    output logic [31:0]      position_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int pos = 0;
    int stp;
    assign stp = speed_hi_i ? 4 : 1;
    always_ff @(posedge clk_i) begin
        stopped_o <= !run_i;
        if (load_i) pos <= int'(load_pos_i);
        else if (run_i) pos <= dir_fwd_i ? pos + stp : pos - stp;
    end
    // index mark wide enough to pass the pin synchroniser at low speed
    assign home_switch_o   = pos >= 400 && pos <= 500;
    assign reverse_limit_o = pos <= 64;
    assign forward_limit_o = pos >= 960;
    assign index_pulse_o   = pos[5:0] < 6'h08;
    assign position_o      = pos;
endmodule : hmsq_axis

/* bench/hmsq_core_test.sv */
// bench for the homing sequencer: table of starts, then hand tests
// assumes hmsq_axis stands at the sensor side
`include "hmsq_map.svh"
module hmsq_core_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [4:0] m;
        logic [9:0] p;
        logic       d;
        logic       a;
        logic       r;
    } hmsq_row_s;
    logic clk_i = 0, reset_i = 1, start_i = 0, alarm_clr_i = 0;
    logic [`HM_MODE_W-1:0] mode_i = 5'h00;
    logic load_i = 0;
    logic [9:0] load_pos_i = 10'h000;
    logic hs, fl, rl, ix, stp, run_o, dir_fwd_o, speed_hi_o;
    logic busy_o, done_o, alarm_o, reject_o;
    logic [31:0] pos, home_pos_o;
    int failures = 0, checks_done = 0;
    hmsq_row_s rows [20] = '{
        '{5'h0C,10'h2BC,1,0,0}, '{5'h0C,10'h0C8,1,0,0},
        '{5'h0C,10'h1C2,1,0,0}, '{5'h0D,10'h2BC,1,0,0},
        '{5'h0D,10'h0C8,1,0,0}, '{5'h0D,10'h1C2,1,0,0},
        '{5'h0E,10'h2BC,1,0,0}, '{5'h0E,10'h0C8,1,0,0},
        '{5'h0E,10'h1C2,1,0,0}, '{5'h11,10'h0C8,1,0,0},
        '{5'h11,10'h01E,1,0,0}, '{5'h12,10'h2BC,1,0,0},
        '{5'h12,10'h3DE,1,0,0}, '{5'h13,10'h0C8,1,0,0},
        '{5'h13,10'h1C2,1,0,0}, '{5'h13,10'h384,0,1,0},
        '{5'h0F,10'h0C8,0,0,1}, '{5'h10,10'h0C8,0,0,1},
        '{5'h0B,10'h0C8,0,0,1}, '{5'h14,10'h0C8,0,0,1}};
    always #25 clk_i = ~clk_i;
    hmsq_axis axis (.clk_i(clk_i), .load_i(load_i), .load_pos_i(load_pos_i),
        .run_i(run_o), .dir_fwd_i(dir_fwd_o), .speed_hi_i(speed_hi_o),
        .home_switch_o(hs), .forward_limit_o(fl), .reverse_limit_o(rl),
        .index_pulse_o(ix), .stopped_o(stp), .position_o(pos));
    hmsq_core dut (.clk_i(clk_i), .reset_i(reset_i), .start_i(start_i),
        .mode_i(mode_i), .home_switch_i(hs), .forward_limit_i(fl),
        .reverse_limit_i(rl), .index_pulse_i(ix), .position_i(pos),
        .stopped_i(stp), .alarm_clr_i(alarm_clr_i), .run_o(run_o),
        .dir_fwd_o(dir_fwd_o), .speed_hi_o(speed_hi_o), .busy_o(busy_o),
        .done_o(done_o), .alarm_o(alarm_o), .reject_o(reject_o),
        .home_pos_o(home_pos_o));
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        checks_done++;
        if (seen !== ex) begin
            failures++;
            $display("[ERR] %s exp %0h seen %0h", nm, ex, seen);
        end
    endtask : chk
    task results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    // place the axis, let the synchroniser settle, then pulse start
    task go(input hmsq_row_s r);
        int n;
        @(posedge clk_i) begin load_i <= 1; load_pos_i <= r.p; end
        @(posedge clk_i) load_i <= 0;
        repeat (5) @(posedge clk_i);
        mode_i <= r.m;
        start_i <= 1;
        @(posedge clk_i) start_i <= 0;
        @(negedge clk_i);
        chk("busy", busy_o, !r.r);
        n = 0;
        while (!(done_o | alarm_o | reject_o) && n < 6000) begin
            @(negedge clk_i);
            n++;
        end
    endtask : go
    initial begin
        repeat (50000) @(posedge clk_i);
        failures++;
        results;
    end
    initial begin
        repeat (2) @(posedge clk_i);
        chk("rst", {run_o, busy_o, done_o, alarm_o, reject_o}, 0);
        reset_i <= 0;
        foreach (rows[i]) begin
            go(rows[i]);
            chk("done", done_o, rows[i].d);
            chk("alarm", alarm_o, rows[i].a);
            chk("reject", reject_o, rows[i].r);
            if (done_o === 1'b1 && rows[i].m > 5'h0E)
                chk("hpos", home_pos_o, pos);
            if (done_o === 1'b1 && rows[i].m <= 5'h0E)
                chk("hidx", home_pos_o[5:0] < 6'h08, 1);
            @(negedge clk_i);
            chk("rej1", reject_o, 0);
            chk("run", run_o, 0);
            if (rows[i].a) begin
                @(posedge clk_i) alarm_clr_i <= 1;
                @(posedge clk_i) alarm_clr_i <= 0;
                @(negedge clk_i);
                chk("alarm_clr", alarm_o, 0);
            end
            $display("row %0d ended", i);
        end
        // alarm stays and start is ignored until cleared
        go(rows[15]);
        @(posedge clk_i) begin mode_i <= 5'h11; start_i <= 1; end
        @(posedge clk_i) start_i <= 0;
        @(negedge clk_i);
        chk("alarm_held", {alarm_o, busy_o, reject_o}, 3'b100);
        @(posedge clk_i) alarm_clr_i <= 1;
        @(posedge clk_i) alarm_clr_i <= 0;
        repeat (2) @(posedge clk_i);
        go(rows[9]);
        chk("after_clr", {done_o, alarm_o}, 2'b10);
        $display("alarm test ended");
        // reset in mid-run drops the sequence
        @(posedge clk_i) begin load_i <= 1; load_pos_i <= 10'h0C8; end
        @(posedge clk_i) load_i <= 0;
        repeat (5) @(posedge clk_i);
        mode_i <= 5'h11;
        start_i <= 1;
        @(posedge clk_i) start_i <= 0;
        repeat (20) @(posedge clk_i);
        reset_i <= 1;
        repeat (2) @(posedge clk_i);
        chk("mid_rst", {run_o, busy_o, done_o}, 0);
        $display("reset test ended");
        results;
    end
endmodule : hmsq_core_test
